/* rtl/seq_consts.svh */
// Purpose: shared constants of the sleep and wake sequencer
// Assumes: 100 MHz ref_clk, AXI4-Lite byte addresses
// Notes: defaults, limits, offsets and tick counts
// What this block does
// - Sleep line changes only after sleep_cycle_count periods unless RF data waits or, in mode 5, the pin wakes it
// - Sleep lasts sleep_period tens of ms, 0x20 to 0xAF0, default 0x20
// - Parent buffers child messages for its own sleep_period
// - Awake hold timer restarts on serial or RF data; sleep after expiry
// - Option 0x02 keeps the device awake for the full hold time
// - Option 0x04 sleeps count times period with no intermediate wakes
// - Nonzero wake_processor_delay holds off host output that many ms
// - Any serial character from the host stops the wake delay
// - Parent polled every parent_query_rate tens of ms; zero means 100 ms
// - Queued values apply only on commit, mode leave or API apply
// - Action commands act at once without an apply step
// - Soft reboot answers OK at once and resets 100 ms later
// - Factory defaults restore parameters; read-only values stay untouched
// - Doze now sleeps at once, only when sent as API frame
// - Command mode ends only on leave command or timeout
// - Button emulation acts as 1, 2 or 4 presses only
// - Sleep behavior 0 off, 1 pin, 4 cyclic, 5 cyclic with pin wake
`ifndef SEQ_CONSTS_SVH
`define SEQ_CONSTS_SVH
`define CLK_NS 10
`define MS_NS 1000000
`define MS_CYCLES (`MS_NS / `CLK_NS)
`define MS_PER_TEN 4'hA
`define POLL_DEF_MS 100
`define POLL_STEP_MS 10
`define REBOOT_MS 100
`define ADDR_MODE 8'h00
`define ADDR_CYCLES 8'h04
`define ADDR_PERIOD 8'h08
`define ADDR_HOLD 8'h0C
`define ADDR_OPTS 8'h10
`define ADDR_WAKE 8'h14
`define ADDR_POLL 8'h18
`define ADDR_BAUD 8'h1C
`define ADDR_CMD 8'h20
`define ADDR_STATUS 8'h24
`define MODE_OFF 3'h0
`define MODE_PIN 3'h1
`define MODE_CYCLIC 3'h4
`define MODE_CYC_PIN 3'h5
`define DEF_MODE 3'h4
`define DEF_CYCLES 16'h0001
`define DEF_PERIOD 16'h0020
`define MIN_PERIOD 16'h0020
`define MAX_PERIOD 16'h0AF0
`define DEF_HOLD 16'h1388
`define DEF_OPTS 8'h00
`define OPT_ALWAYS 1
`define OPT_FULL 2
`define DEF_WAKE 16'h0000
`define DEF_POLL 16'h0000
`define MAX_POLL 16'h03E8
`define DEF_BAUD 4'h3
`define CMD_API_BIT 8
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

/* rtl/seq_pkg.sv */
// Purpose: types of the sleep and wake sequencer
// Assumes: seq_consts.svh holds all default values
// Notes: defaultCfg gives the factory settings
`include "seq_consts.svh"
package seq_pkg;
  typedef enum logic [2:0] {
    ST_AWAKE = 3'b001,
    ST_SLEEP = 3'b010,
    ST_PINSLP = 3'b100
  } state_t;
  typedef enum logic [3:0] {
    CMD_NONE = 4'h0,
    CMD_COMMIT = 4'h1,
    CMD_LEAVE = 4'h2,
    CMD_PERSIST = 4'h3,
    CMD_DEFAULTS = 4'h4,
    CMD_REBOOT = 4'h5,
    CMD_DOZE = 4'h6,
    CMD_BUTTON = 4'h7
  } cmd_t;
  typedef struct packed {
    logic [2:0] mode;
    logic [15:0] cycles;
    logic [15:0] period;
    logic [15:0] hold;
    logic [7:0] opts;
    logic [15:0] wake;
    logic [15:0] poll;
    logic [3:0] baud;
  } cfg_t;
  function automatic cfg_t defaultCfg();
    cfg_t c;
    c.mode = `DEF_MODE;
    c.cycles = `DEF_CYCLES;
    c.period = `DEF_PERIOD;
    c.hold = `DEF_HOLD;
    c.opts = `DEF_OPTS;
    c.wake = `DEF_WAKE;
    c.poll = `DEF_POLL;
    c.baud = `DEF_BAUD;
    return c;
  endfunction : defaultCfg
endpackage : seq_pkg

/* rtl/tick_prescaler.sv */
// Purpose: millisecond and 10 ms ticks from ref_clk
// Assumes: MS_CYCLES clocks per millisecond
// Notes: ticks are one-cycle pulses
`timescale 1ns/10ps
`default_nettype none
`include "seq_consts.svh"
module tick_prescaler
#(
  parameter int MS_CYCLES = `MS_CYCLES
)
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic clkEn,
  output logic msTick,
  output logic tenMsTick
);
  logic [31:0] cyc, next_cyc;
  logic [3:0] tens, next_tens;
  logic next_msTick, next_tenMsTick;
  logic wrap;

  always_comb
  begin
    wrap = cyc == 32'(MS_CYCLES - 1);
    next_cyc = wrap ? 32'h0 : cyc + 32'h1;
    next_tens = tens;
    next_msTick = wrap;
    next_tenMsTick = 1'b0;
    if (wrap)
    begin
      next_tenMsTick = tens == `MS_PER_TEN - 4'h1;
      next_tens = next_tenMsTick ? 4'h0 : tens + 4'h1;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cyc <= 32'h0;
      tens <= 4'h0;
      msTick <= 1'b0;
      tenMsTick <= 1'b0;
    end
    else if (clkEn)
    begin
      cyc <= next_cyc;
      tens <= next_tens;
      msTick <= next_msTick;
      tenMsTick <= next_tenMsTick;
    end
  end
endmodule : tick_prescaler
`default_nettype wire

/* rtl/down_timer.sv */
// Purpose: 16-bit tick down counter
// Assumes: load has priority over counting
// Notes: done while the count is zero
`timescale 1ns/10ps
`default_nettype none
module down_timer
#(
  parameter logic [15:0] RST_VAL = 16'h0000
)
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic clkEn,
  input wire logic tick,
  input wire logic load,
  input wire logic [15:0] loadVal,
  output logic done
);
  logic [15:0] cnt, next_cnt;

  always_comb
  begin
    next_cnt = cnt;
    if (load)
      next_cnt = loadVal;
    else if (tick && cnt != 16'h0000)
      next_cnt = cnt - 16'h0001;
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      cnt <= RST_VAL;
    else if (clkEn)
      cnt <= next_cnt;
  end

  assign done = cnt == 16'h0000;
endmodule : down_timer
`default_nettype wire

/* rtl/end_device_sleep_wake_sequencer.sv */
// Purpose: sleep, wake and action-command sequencing of an end device
// Assumes: host events are synchronous one-cycle pulses
// Notes: registers over AXI4-Lite, pending set applied on commit
`timescale 1ns/10ps
`default_nettype none
`include "seq_consts.svh"
module end_device_sleep_wake_sequencer
  import seq_pkg::*;
#(
  parameter int MS_CYCLES = `MS_CYCLES
)
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic clkEn,
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  input wire logic [2:0] arprot,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  input wire logic hostRxChar,
  input wire logic rfRxData,
  input wire logic rfPending,
  input wire logic sleepReq,
  input wire logic cmdModeEnter,
  input wire logic cmdTimeout,
  input wire logic apiApply,
  output logic dozeIndicator,
  output logic hostTxAllow,
  output logic pollStrobe,
  output logic [15:0] parentHoldTime,
  output logic [3:0] serialRate,
  output logic cmdModeActive,
  output logic cmdAck,
  output logic persistReq,
  output logic softReset,
  output logic buttonStrobe,
  output logic [2:0] buttonPresses
);
  state_t state, next_state;
  cfg_t pend, next_pend, act, next_act;
  logic [15:0] periodCnt, next_periodCnt;
  logic cmdMode, next_cmdMode, rebootArmed, next_rebootArmed;
  logic next_cmdAck, next_persistReq, next_softReset, next_pollStrobe;
  logic next_buttonStrobe;
  logic [2:0] next_buttonPresses;
  logic awHeld, next_awHeld, wHeld, next_wHeld;
  logic [7:0] awAddr, next_awAddr;
  logic [31:0] wData, next_wData, next_rdata;
  logic [3:0] wStrb, next_wStrb;
  logic next_bvalid, next_rvalid;
  logic [1:0] next_bresp, next_rresp;
  logic msTick, tenMsTick;
  logic holdDone, wakeDone, rebootDone, sleepDone, pollDone;
  logic holdLoad, wakeLoad, sleepLoad, pollLoad, rebootLoad;
  logic [15:0] wakeVal, pollVal;
  logic stAwake, stSleep, cyclic, activity, pinWake, fullSleep;
  logic wrGo, cmdGo, cmdApi, sleepGo, dozeGo, periodEnd, enterAwake;
  logic applyGo, defaultsGo, actLoad, cmdExit, buttonOk;
  logic [32:0] wrOld;
  logic [31:0] wrVal;
  logic [16:0] cntNext;
  logic [6:0] status;
  cmd_t cmdCode;

  function automatic logic [32:0] regRead(input logic [7:0] a, input cfg_t c,
                                          input logic [6:0] st);
    logic [32:0] r;
    r = {1'b1, 32'h0};
    case (a)
      `ADDR_MODE: r[2:0] = c.mode;
      `ADDR_CYCLES: r[15:0] = c.cycles;
      `ADDR_PERIOD: r[15:0] = c.period;
      `ADDR_HOLD: r[15:0] = c.hold;
      `ADDR_OPTS: r[7:0] = c.opts;
      `ADDR_WAKE: r[15:0] = c.wake;
      `ADDR_POLL: r[15:0] = c.poll;
      `ADDR_BAUD: r[3:0] = c.baud;
      `ADDR_CMD: r[32] = 1'b1;
      `ADDR_STATUS: r[6:0] = st;
      default: r[32] = 1'b0;
    endcase
    return r;
  endfunction : regRead

  function automatic logic [31:0] mergeBytes(input logic [31:0] o,
                                             input logic [31:0] n,
                                             input logic [3:0] s);
    logic [31:0] m;
    m = o;
    for (int i = 0; i < 4; i++)
      if (s[i])
        m[i*8 +: 8] = n[i*8 +: 8];
    return m;
  endfunction : mergeBytes

  function automatic logic inRange(input logic [15:0] v, input logic [15:0] lo,
                                   input logic [15:0] hi);
    return v >= lo && v <= hi;
  endfunction : inRange

  tick_prescaler #(.MS_CYCLES(MS_CYCLES)) ticks (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .clkEn(clkEn),
    .msTick(msTick),
    .tenMsTick(tenMsTick)
  );
  down_timer #(.RST_VAL(`DEF_HOLD)) holdT (
    .ref_clk(ref_clk), .rstn(rstn), .clkEn(clkEn), .tick(msTick),
    .load(holdLoad), .loadVal(act.hold), .done(holdDone)
  );
  down_timer #(.RST_VAL(`DEF_WAKE)) wakeT (
    .ref_clk(ref_clk), .rstn(rstn), .clkEn(clkEn), .tick(msTick),
    .load(wakeLoad), .loadVal(wakeVal), .done(wakeDone)
  );
  down_timer #(.RST_VAL(16'h0000)) rebootT (
    .ref_clk(ref_clk), .rstn(rstn), .clkEn(clkEn), .tick(msTick),
    .load(rebootLoad), .loadVal(16'(`REBOOT_MS)), .done(rebootDone)
  );
  down_timer #(.RST_VAL(`DEF_PERIOD)) sleepT (
    .ref_clk(ref_clk), .rstn(rstn), .clkEn(clkEn), .tick(tenMsTick),
    .load(sleepLoad), .loadVal(act.period), .done(sleepDone)
  );
  down_timer #(.RST_VAL(16'(`POLL_DEF_MS / `POLL_STEP_MS))) pollT (
    .ref_clk(ref_clk), .rstn(rstn), .clkEn(clkEn), .tick(tenMsTick),
    .load(pollLoad), .loadVal(pollVal), .done(pollDone)
  );

  assign awready = clkEn && !awHeld;
  assign wready = clkEn && !wHeld;
  assign arready = clkEn && !rvalid;
  assign stAwake = state == ST_AWAKE;
  assign stSleep = state == ST_SLEEP;
  assign hostTxAllow = stAwake && wakeDone;
  assign dozeIndicator = !stAwake;
  assign cmdModeActive = cmdMode;
  assign parentHoldTime = act.period;
  assign serialRate = act.baud;
  assign status = {rebootArmed, cmdMode, hostTxAllow, dozeIndicator, state};

  always_comb
  begin
    wrGo = clkEn && awHeld && wHeld && !bvalid;
    wrOld = regRead(awAddr, pend, status);
    wrVal = mergeBytes(wrOld[31:0], wData, wStrb);
    cmdGo = wrGo && awAddr == `ADDR_CMD && wStrb[0];
    cmdCode = cmd_t'(wrVal[3:0]);
    cmdApi = wrVal[`CMD_API_BIT];
    cyclic = act.mode == `MODE_CYCLIC || act.mode == `MODE_CYC_PIN;
    activity = hostRxChar || rfRxData;
    pinWake = act.mode == `MODE_CYC_PIN && !sleepReq;
    fullSleep = act.opts[`OPT_FULL];
    dozeGo = cmdGo && cmdCode == CMD_DOZE && cmdApi && cyclic
             && !act.opts[`OPT_ALWAYS];
    sleepGo = clkEn && stAwake && cyclic
              && ((holdDone && !rfPending && !activity) || dozeGo);
    periodEnd = clkEn && stSleep && sleepDone;
    cntNext = {1'b0, periodCnt} + 17'h00001;
    applyGo = (cmdGo && (cmdCode == CMD_COMMIT || cmdCode == CMD_LEAVE))
              || (clkEn && apiApply);
    defaultsGo = cmdGo && cmdCode == CMD_DEFAULTS;
    actLoad = applyGo || defaultsGo;
    cmdExit = (cmdGo && cmdCode == CMD_LEAVE) || (clkEn && cmdTimeout);
    buttonOk = wrVal[7:4] == 4'h1 || wrVal[7:4] == 4'h2 || wrVal[7:4] == 4'h4;
  end

  always_comb
  begin
    next_state = state;
    next_periodCnt = periodCnt;
    next_pollStrobe = 1'b0;
    sleepLoad = 1'b0;
    case (state)
      ST_AWAKE:
      begin
        if (act.mode == `MODE_PIN && sleepReq)
          next_state = ST_PINSLP;
        else if (sleepGo)
        begin
          next_state = ST_SLEEP;
          next_periodCnt = 16'h0000;
          sleepLoad = 1'b1;
        end
        else if (pollDone && act.mode != `MODE_OFF)
          next_pollStrobe = 1'b1;
      end
      ST_SLEEP:
      begin
        if (pinWake)
          next_state = ST_AWAKE;
        else if (periodEnd)
        begin
          if (cntNext >= {1'b0, act.cycles})
            next_state = ST_AWAKE;
          else if (!fullSleep && rfPending)
            next_state = ST_AWAKE;
          else
          begin
            next_periodCnt = cntNext[15:0];
            sleepLoad = 1'b1;
            next_pollStrobe = !fullSleep;
          end
        end
      end
      ST_PINSLP:
      begin
        if (!sleepReq || act.mode != `MODE_PIN)
          next_state = ST_AWAKE;
      end
      default: next_state = ST_AWAKE;
    endcase
    enterAwake = next_state == ST_AWAKE && !stAwake;
    holdLoad = activity || enterAwake;
    wakeLoad = hostRxChar || enterAwake;
    wakeVal = hostRxChar ? 16'h0000 : act.wake;
    pollLoad = enterAwake || (stAwake && pollDone);
    pollVal = act.poll == 16'h0000 ? 16'(`POLL_DEF_MS / `POLL_STEP_MS) : act.poll;
  end

  always_comb
  begin
    next_pend = pend;
    next_act = act;
    next_cmdAck = 1'b0;
    next_persistReq = 1'b0;
    next_softReset = 1'b0;
    next_buttonStrobe = 1'b0;
    next_buttonPresses = buttonPresses;
    next_rebootArmed = rebootArmed;
    rebootLoad = 1'b0;
    next_cmdMode = (cmdMode && !cmdExit) || (clkEn && cmdModeEnter);
    if (wrGo && !cmdGo)
      case (awAddr)
        `ADDR_MODE:
          if (wrVal[2:0] == `MODE_OFF || wrVal[2:0] == `MODE_PIN
              || wrVal[2:0] == `MODE_CYCLIC || wrVal[2:0] == `MODE_CYC_PIN)
            next_pend.mode = wrVal[2:0];
        `ADDR_CYCLES:
          if (wrVal[15:0] != 16'h0000)
            next_pend.cycles = wrVal[15:0];
        `ADDR_PERIOD:
          if (inRange(wrVal[15:0], `MIN_PERIOD, `MAX_PERIOD))
            next_pend.period = wrVal[15:0];
        `ADDR_HOLD:
          if (wrVal[15:0] != 16'h0000)
            next_pend.hold = wrVal[15:0];
        `ADDR_OPTS: next_pend.opts = wrVal[7:0];
        `ADDR_WAKE: next_pend.wake = wrVal[15:0];
        `ADDR_POLL:
          if (inRange(wrVal[15:0], `DEF_POLL, `MAX_POLL))
            next_pend.poll = wrVal[15:0];
        `ADDR_BAUD: next_pend.baud = wrVal[3:0];
        default: next_pend = pend;
      endcase
    if (applyGo)
      next_act = pend;
    if (cmdGo)
    begin
      next_cmdAck = cmdCode != CMD_BUTTON || buttonOk;
      case (cmdCode)
        CMD_PERSIST: next_persistReq = 1'b1;
        CMD_DEFAULTS:
        begin
          next_pend = defaultCfg();
          next_act = defaultCfg();
        end
        CMD_REBOOT:
        begin
          rebootLoad = 1'b1;
          next_rebootArmed = 1'b1;
        end
        CMD_BUTTON:
          if (buttonOk)
          begin
            next_buttonStrobe = 1'b1;
            next_buttonPresses = wrVal[6:4];
          end
        default: next_cmdAck = next_cmdAck;
      endcase
    end
    if (clkEn && rebootArmed && rebootDone && !rebootLoad)
    begin
      next_softReset = 1'b1;
      next_rebootArmed = 1'b0;
    end
  end

  always_comb
  begin
    next_awHeld = awHeld;
    next_awAddr = awAddr;
    next_wHeld = wHeld;
    next_wData = wData;
    next_wStrb = wStrb;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_rvalid = rvalid;
    next_rdata = rdata;
    next_rresp = rresp;
    if (awvalid && awready)
    begin
      next_awHeld = 1'b1;
      next_awAddr = awaddr;
    end
    if (wvalid && wready)
    begin
      next_wHeld = 1'b1;
      next_wData = wdata;
      next_wStrb = wstrb;
    end
    if (bvalid && bready)
      next_bvalid = 1'b0;
    if (wrGo)
    begin
      next_awHeld = 1'b0;
      next_wHeld = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = wrOld[32] ? `RESP_OKAY : `RESP_SLVERR;
    end
    if (rvalid && rready)
      next_rvalid = 1'b0;
    if (arvalid && arready)
    begin
      next_rvalid = 1'b1;
      {next_rresp[1], next_rdata} = regRead(araddr, pend, status) ^ {1'b1, 32'h0};
      next_rresp[0] = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state <= ST_AWAKE;
      periodCnt <= 16'h0000;
      pend <= defaultCfg();
      act <= defaultCfg();
      cmdMode <= 1'b0;
      rebootArmed <= 1'b0;
      cmdAck <= 1'b0;
      persistReq <= 1'b0;
      softReset <= 1'b0;
      pollStrobe <= 1'b0;
      buttonStrobe <= 1'b0;
      buttonPresses <= 3'h0;
      awHeld <= 1'b0;
      awAddr <= 8'h00;
      wHeld <= 1'b0;
      wData <= 32'h0;
      wStrb <= 4'h0;
      bvalid <= 1'b0;
      bresp <= 2'h0;
      rvalid <= 1'b0;
      rdata <= 32'h0;
      rresp <= 2'h0;
    end
    else if (clkEn)
    begin
      state <= next_state;
      periodCnt <= next_periodCnt;
      pend <= next_pend;
      act <= next_act;
      cmdMode <= next_cmdMode;
      rebootArmed <= next_rebootArmed;
      cmdAck <= next_cmdAck;
      persistReq <= next_persistReq;
      softReset <= next_softReset;
      pollStrobe <= next_pollStrobe;
      buttonStrobe <= next_buttonStrobe;
      buttonPresses <= next_buttonPresses;
      awHeld <= next_awHeld;
      awAddr <= next_awAddr;
      wHeld <= next_wHeld;
      wData <= next_wData;
      wStrb <= next_wStrb;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
    end
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);

  sequence rebootCmd_s;
    cmdGo && cmdCode == CMD_REBOOT;
  endsequence
  sequence okNoReset_s;
    cmdAck && !softReset ##1 !softReset;
  endsequence

  sleepCount_a: assert property (
    stSleep && periodEnd && !rfPending && !pinWake
    && cntNext < {1'b0, act.cycles} |=> stSleep)
    else $error("woke before sleep count");
  holdRestart_a: assert property (
    clkEn && stAwake && activity && !dozeGo |=> !stSleep)
    else $error("slept despite activity");
  alwaysWake_a: assert property (
    cmdGo && cmdCode == CMD_DOZE && act.opts[`OPT_ALWAYS] && !holdDone
    |=> !stSleep)
    else $error("doze cut hold time short");
  fullSleep_a: assert property (
    stSleep && $past(stSleep) && fullSleep |-> !pollStrobe)
    else $error("intermediate wake in full sleep");
  wakeDelay_a: assert property (
    clkEn && enterAwake && act.wake != 16'h0000 && !hostRxChar
    |=> !hostTxAllow)
    else $error("host output not delayed");
  wakeStop_a: assert property (
    clkEn && hostRxChar && stAwake |=> hostTxAllow || !stAwake)
    else $error("wake delay not stopped");
  actApply_a: assert property (
    $changed(act) |-> $past(actLoad))
    else $error("active set changed without apply");
  rebootOk_a: assert property (
    rebootCmd_s |=> okNoReset_s)
    else $error("reboot ok missing or early reset");
  dozeApi_a: assert property (
    cmdGo && cmdCode == CMD_DOZE && !cmdApi && !holdDone |=> !stSleep)
    else $error("doze acted outside api");
  cmdLeave_a: assert property (
    $fell(cmdMode) |-> $past(cmdExit))
    else $error("command mode left without cause");
  buttonCount_a: assert property (
    buttonStrobe |-> buttonPresses == 3'h1 || buttonPresses == 3'h2
    || buttonPresses == 3'h4)
    else $error("illegal button count");
endmodule : end_device_sleep_wake_sequencer
`default_nettype wire

/* test/host_model.sv */
// Purpose: host processor on the serial side of the sequencer
// Assumes: one character per send request
// Notes: holds characters back after a persist until the OK
`timescale 1ns/10ps
`default_nettype none
module host_model
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic sendReq,
  input wire logic persistReq,
  input wire logic cmdAck,
  output logic hostRxChar
);
  logic waitOk;

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      waitOk <= 1'b0;
      hostRxChar <= 1'b0;
    end
    else
    begin
      waitOk <= (persistReq || waitOk) && !cmdAck;
      hostRxChar <= sendReq && !waitOk && !persistReq;
    end
  end
endmodule : host_model
`default_nettype wire

/* test/tb_end_device_sleep_wake_sequencer.sv */
// Purpose: self-checking bench of the sleep and wake sequencer
// Assumes: MS_CYCLES of 10, so one ms is 10 clocks
// Notes: pending register set modelled in an int array
`timescale 1ns/10ps
`default_nettype none
`include "seq_consts.svh"
module tb_end_device_sleep_wake_sequencer;
  import seq_pkg::*;
  logic ref_clk, rstn, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid;
  logic arready, rvalid, rfRxData, rfPending, sleepReq, cmdModeEnter, cmdTimeout, apiApply;
  logic sendReq, hostRxChar, dozeIndicator, hostTxAllow, cmdModeActive, cmdAck, persistReq;
  logic softReset, buttonStrobe, pollStrobe, clkEn;
  logic [2:0] seen, buttonPresses;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, v;
  logic [1:0] bresp, rresp, resp;
  logic [15:0] parentHoldTime, lfsr;
  logic [3:0] serialRate;
  int num_errors, cmp_count, n, c;
  int pend[8];

  end_device_sleep_wake_sequencer #(.MS_CYCLES(10)) i_dut (
    .ref_clk, .rstn, .clkEn, .awvalid, .awready, .awaddr, .awprot(3'h0), .wvalid,
    .wready, .wdata, .wstrb(4'hF), .bvalid, .bready, .bresp, .arvalid, .arready, .araddr,
    .arprot(3'h0), .rvalid, .rready, .rdata, .rresp, .hostRxChar, .rfRxData, .rfPending,
    .sleepReq, .cmdModeEnter, .cmdTimeout, .apiApply, .dozeIndicator, .hostTxAllow,
    .pollStrobe, .parentHoldTime, .serialRate, .cmdModeActive, .cmdAck, .persistReq,
    .softReset, .buttonStrobe, .buttonPresses);
  host_model i_host (.ref_clk, .rstn, .sendReq, .persistReq, .cmdAck, .hostRxChar);

  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  function automatic logic [15:0] nxt(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : nxt

  task automatic step(input int k);
    repeat (k) @(posedge ref_clk);
  endtask : step

  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic endt(input string s);
    $display("test %s done", s);
  endtask : endt

  task automatic complete_run();
    $display("counts: %0d compares, %0d mismatches", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : complete_run

  // Pulses seen up to one cycle after the response: ack, button, persist
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    seen = 3'h0;
    awaddr <= a;
    wdata <= d;
    {awvalid, wvalid, bready} <= 3'h7;
    n = 0;
    do
    begin
      @(posedge ref_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      seen |= {cmdAck, buttonStrobe, persistReq};
      n++;
    end
    while (!bvalid && n < 60);
    resp = bresp;
    bready <= 1'b0;
    if (n >= 60) num_errors++;
    @(posedge ref_clk);
    seen |= {cmdAck, buttonStrobe, persistReq};
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    araddr <= a;
    {arvalid, rready} <= 2'h3;
    n = 0;
    do
    begin
      @(posedge ref_clk);
      if (arready) arvalid <= 1'b0;
      n++;
    end
    while (!rvalid && n < 60);
    d = rdata;
    resp = rresp;
    rready <= 1'b0;
    if (n >= 60) num_errors++;
    @(posedge ref_clk);
  endtask : rd

  task automatic rw(input logic [7:0] a, input logic [31:0] d);
    wr(a, d);
    pend[a[4:2]] = int'(d);
  endtask : rw

  task automatic dflt();
    pend = '{`DEF_MODE, `DEF_CYCLES, `DEF_PERIOD, `DEF_HOLD, `DEF_OPTS, `DEF_WAKE,
      `DEF_POLL, `DEF_BAUD};
  endtask : dflt

  task automatic rdAll();
    for (int i = 0; i < 8; i++)
    begin
      rd(8'(i * 4), v);
      chk(v, pend[i]);
    end
  endtask : rdAll

  // Order: enter, timeout, apply, host character
  task automatic pulseIn(input logic [3:0] m);
    {cmdModeEnter, cmdTimeout, apiApply, sendReq} <= m;
    step(1);
    {cmdModeEnter, cmdTimeout, apiApply, sendReq} <= 4'h0;
    step(3);
  endtask : pulseIn

  initial
  begin
    #600000;
    num_errors++;
    complete_run();
  end

  initial
  begin
    {rstn, awvalid, wvalid, bready, arvalid, rready, rfRxData, rfPending, sleepReq} = '0;
    {cmdModeEnter, cmdTimeout, apiApply, sendReq, awaddr, araddr, wdata} = '0;
    clkEn = 1'b1;
    num_errors = 0;
    cmp_count = 0;
    lfsr = 16'h0060;
    dflt();
    step(16);
    rstn <= 1'b1;
    step(1);
    chk({dozeIndicator, hostTxAllow, cmdModeActive, parentHoldTime, serialRate},
      {3'b010, `DEF_PERIOD, `DEF_BAUD});
    rdAll();
    rd(8'h28, v);
    chk({resp, v}, {`RESP_SLVERR, 32'h0});
    wr(8'h28, 32'h1);
    chk(resp, `RESP_SLVERR);
    endt("registers");
    lfsr = nxt(lfsr);
    rw(`ADDR_BAUD, {28'h0, 1'b1, lfsr[2:0]});
    rw(`ADDR_PERIOD, 32'h40);
    chk({serialRate, parentHoldTime}, {`DEF_BAUD, `DEF_PERIOD});
    pulseIn(4'h2);
    chk({serialRate, parentHoldTime}, {pend[7][3:0], 16'h0040});
    rw(`ADDR_BAUD, 32'h5);
    wr(`ADDR_CMD, 32'h1);
    chk({seen[2], serialRate}, 5'h15);
    endt("queued");
    pulseIn(4'h8);
    chk(cmdModeActive, 1'b1);
    wr(`ADDR_CMD, 32'h6);
    chk({seen[2], dozeIndicator, cmdModeActive}, 3'b101);
    pulseIn(4'h4);
    chk(cmdModeActive, 1'b0);
    pulseIn(4'h8);
    rw(`ADDR_BAUD, 32'h6);
    wr(`ADDR_CMD, 32'h2);
    chk({cmdModeActive, serialRate}, 5'h06);
    // Frozen block ignores the enter pulse
    clkEn <= 1'b0;
    pulseIn(4'h8);
    clkEn <= 1'b1;
    chk(cmdModeActive, 1'b0);
    endt("command mode");
    for (int k = 1; k < 5; k++)
    begin
      wr(`ADDR_CMD, 32'((k << 4) | 7));
      chk({seen[2:1], k == 3 ? 3'h0 : buttonPresses}, k == 3 ? 5'h0 : {2'b11, 3'(k)});
    end
    wr(`ADDR_CMD, 32'h3);
    chk(seen, 3'b101);
    endt("actions");
    rw(`ADDR_OPTS, 32'h2);
    rw(`ADDR_PERIOD, 32'h20);
    rw(`ADDR_WAKE, 32'd20);
    wr(`ADDR_CMD, 32'h1);
    wr(`ADDR_CMD, 32'h106);
    chk(dozeIndicator, 1'b0);
    rw(`ADDR_OPTS, 32'h0);
    wr(`ADDR_CMD, 32'h1);
    wr(`ADDR_CMD, 32'h106);
    chk(dozeIndicator, 1'b1);
    for (c = 0; c < 4000 && dozeIndicator; c++)
      step(1);
    chk(c >= 3000 && c <= 3400, 1'b1);
    step(2);
    chk(hostTxAllow, 1'b0);
    pulseIn(4'h1);
    chk(hostTxAllow, 1'b1);
    endt("sleep");
    // Two periods: full sleep ignores waiting data, else a poll between
    rw(`ADDR_CYCLES, 32'h2);
    for (int k = 0; k < 2; k++)
    begin
      rw(`ADDR_OPTS, k ? 32'h0 : 32'h4);
      wr(`ADDR_CMD, 32'h1);
      rfPending <= !k;
      wr(`ADDR_CMD, 32'h106);
      seen = 3'h0;
      for (c = 0; c < 8000 && dozeIndicator; c++)
      begin
        step(1);
        seen[0] |= pollStrobe;
      end
      rfPending <= 1'b0;
      chk({seen[0], c >= 6200 && c <= 6600}, {k[0], 1'b1});
    end
    endt("cycles");
    wr(`ADDR_CMD, 32'h4);
    dflt();
    rdAll();
    chk(serialRate, `DEF_BAUD);
    wr(`ADDR_CMD, 32'h5);
    for (c = 0; c < 1100 && !softReset; c++)
      step(1);
    chk({seen[2], c >= 990 && c <= 1030}, 2'b11);
    endt("defaults and reboot");
    complete_run();
  end
endmodule : tb_end_device_sleep_wake_sequencer
`default_nettype wire
